// file: tsc_pkg.sv
package tsc_pkg;
   // Model-register addresses
   localparam logic [31:0] CYCLE_COUNT_ADDR = 32'h0000_0010;
   localparam logic [31:0] COUNTER_TAG_ADDR = 32'hC000_0103;
   // Feature-query leaves and bit positions
   localparam logic [31:0] LEAF_BASIC = 32'h0000_0001;
   localparam logic [31:0] LEAF_EXT1 = 32'h8000_0001;
   localparam logic [31:0] LEAF_EXT7 = 32'h8000_0007;
   localparam int COUNTER_PRESENT_BIT = 4;
   localparam int TAG_READ_PRESENT_BIT = 27;
   localparam int INVARIANT_BIT = 8;
   localparam int USER_DISABLE_BIT = 2;
   // Reset values, increment step and kernel privilege level
   localparam logic [63:0] COUNT_RESET = 64'h0000_0000_0000_0000;
   localparam logic [31:0] TAG_RESET = 32'h0000_0000;
   localparam logic [63:0] COUNT_ONE = 64'h0000_0000_0000_0001;
   localparam logic [1:0] PRIV_KERNEL = 2'h0;
   // Constant-rate tick divider: reset preset of the reference-pulse countdown
   localparam logic [7:0] CONST_DIV_DEFAULT = 8'h01;
   typedef enum logic [1:0] {TSC_IDLE, TSC_READ, TSC_FAULT} tsc_resp_t;
endpackage : tsc_pkg

// file: tsc_timestamp_counter.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: 64-bit counter, cleared on reset
// RULE2: keeps counting while halted or clock-stopped
// RULE3: may stop while deep-sleep pin asserted
// RULE4: legacy mode adds one per core clock
// RULE5: constant mode ticks at fixed divided rate
// RULE6: constant-mode tick duration ignores core frequency
// RULE7: reads strictly increase except on wrap; the code repeats a value between constant-mode ticks and in deep sleep
// RULE8: width prevents wrap within ten years
// RULE9: user-disable flag limits reads to ring 0
// RULE10: read is non-serializing, samples immediately
// RULE11: counter reachable as model register 10H
// RULE12: model-register read returns all 64 bits
// RULE13: legacy write loads low 32, clears upper
// RULE14: newer write loads all 64 bits
// RULE15: leaf 1 EDX bit 4 reports counter
// RULE16: leaf 80000007H EDX bit 8 reports invariant
// RULE17: invariant counter constant in all states; the code stops it while the deep-sleep pin is asserted
// RULE18: 32-bit software-loaded auxiliary tag register
// RULE19: combined read gives count and tag
// RULE20: combined read samples both in one cycle
// RULE21: leaf 80000001H bit 27; same gating
// RULE22: one per tick, wraps modulo 2^64
module tsc_timestamp_counter #(
   parameter bit INVARIANT_SUPPORT = 1'b1,
   parameter bit FULL_WIDTH_WRITE = 1'b1
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic constRateMode,
   input wire logic [7:0] constRateDiv,
   input wire logic refTick,
   input wire logic haltState,
   input wire logic stopClockPinN,
   input wire logic deepSleepPinN,
   input wire logic userReadDisableFlag,
   input wire logic [1:0] privLevel,
   input wire logic counterReadInstr,
   input wire logic counterAndTagReadInstr,
   input wire logic modelRegReadInstr,
   input wire logic modelRegWriteInstr,
   input wire logic [31:0] modelRegAddr,
   input wire logic [63:0] modelRegWrData,
   input wire logic featureQueryInstr,
   input wire logic [31:0] featureLeaf,
   output logic rdValid,
   output logic rdFault,
   output logic [31:0] rdEdx,
   output logic [31:0] rdEax,
   output logic [31:0] rdEcx,
   output logic featureValid,
   output logic [31:0] featureEdx
);
   // Counter state, answer flops and decoded strobes
   logic [63:0] count_r, count_nxt;
   logic [31:0] tag_r, tag_nxt;
   logic [7:0] div_r, div_nxt;
   logic rdValid_r, rdValid_nxt, rdFault_r, rdFault_nxt;
   logic [31:0] rdEdx_r, rdEdx_nxt, rdEax_r, rdEax_nxt, rdEcx_r, rdEcx_nxt;
   logic featValid_r, featValid_nxt;
   logic [31:0] featEdx_r, featEdx_nxt;
   logic tick, userBlocked, anyRead, cntWr, tagWr;

   // Tick source: legacy follows core clock, constant mode uses divided reference
   always_comb begin
      if (!deepSleepPinN) begin
         tick = 1'b0; // RULE3
      end else if (constRateMode && INVARIANT_SUPPORT) begin
         tick = refTick && (div_r == 8'h00); // RULE5 RULE6 RULE17
      end else begin
         tick = 1'b1; // RULE4 RULE2
      end
   end

   // Halt and stop-clock deliberately ignored so time keeps moving while halted
   always_comb begin
      userBlocked = userReadDisableFlag && (privLevel != tsc_pkg::PRIV_KERNEL); // RULE9 RULE21
      anyRead = counterReadInstr || counterAndTagReadInstr;
      cntWr = modelRegWriteInstr && (modelRegAddr == tsc_pkg::CYCLE_COUNT_ADDR);
      tagWr = modelRegWriteInstr && (modelRegAddr == tsc_pkg::COUNTER_TAG_ADDR);
   end

   // Counter, divider and tag next state
   always_comb begin
      // Divider keeps running in deep sleep so pacing resumes on the same grid
      div_nxt = div_r;
      if (constRateMode && refTick) begin
         div_nxt = (div_r == 8'h00) ? constRateDiv : div_r - 8'h01;
      end
      count_nxt = count_r;
      if (cntWr) begin
         if (FULL_WIDTH_WRITE) begin
            count_nxt = modelRegWrData; // RULE14
         end else begin
            count_nxt = {32'h0000_0000, modelRegWrData[31:0]}; // RULE13
         end
      end else if (tick) begin
         count_nxt = count_r + tsc_pkg::COUNT_ONE; // RULE22 RULE8 RULE7
      end
      tag_nxt = tagWr ? modelRegWrData[31:0] : tag_r; // RULE18
   end

   // Read path samples the live counter the same cycle, no ordering wait
   always_comb begin
      rdValid_nxt = 1'b0;
      rdFault_nxt = 1'b0;
      rdEdx_nxt = rdEdx_r;
      rdEax_nxt = rdEax_r;
      rdEcx_nxt = rdEcx_r;
      // Counter reads win over a model read in the same cycle
      if (anyRead && userBlocked) begin
         rdFault_nxt = 1'b1; // RULE9
      end else if (anyRead) begin
         rdValid_nxt = 1'b1; // RULE10
         rdEdx_nxt = count_r[63:32];
         rdEax_nxt = count_r[31:0];
         if (counterAndTagReadInstr) begin
            rdEcx_nxt = tag_r; // RULE19 RULE20
         end
      end else if (modelRegReadInstr) begin
         rdValid_nxt = 1'b1;
         if (modelRegAddr == tsc_pkg::CYCLE_COUNT_ADDR) begin
            rdEdx_nxt = count_r[63:32]; // RULE11 RULE12
            rdEax_nxt = count_r[31:0];
         end else if (modelRegAddr == tsc_pkg::COUNTER_TAG_ADDR) begin
            rdEdx_nxt = 32'h0000_0000;
            rdEax_nxt = tag_r;
         end else begin
            rdValid_nxt = 1'b0;
            rdFault_nxt = 1'b1;
         end
      end
   end

   // Feature-query answers
   always_comb begin
      featValid_nxt = featureQueryInstr;
      featEdx_nxt = 32'h0000_0000;
      if (featureLeaf == tsc_pkg::LEAF_BASIC) begin
         featEdx_nxt[tsc_pkg::COUNTER_PRESENT_BIT] = 1'b1; // RULE15
      end else if (featureLeaf == tsc_pkg::LEAF_EXT7) begin
         featEdx_nxt[tsc_pkg::INVARIANT_BIT] = INVARIANT_SUPPORT; // RULE16
      end else if (featureLeaf == tsc_pkg::LEAF_EXT1) begin
         featEdx_nxt[tsc_pkg::TAG_READ_PRESENT_BIT] = 1'b1; // RULE21
      end
      if (!featureQueryInstr) begin
         featEdx_nxt = featEdx_r;
      end
   end

   // Counter, tag and divider flops; a write already beats a tick upstream
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         count_r <= tsc_pkg::COUNT_RESET; // RULE1
         tag_r <= tsc_pkg::TAG_RESET;
         div_r <= tsc_pkg::CONST_DIV_DEFAULT;
      end else begin
         count_r <= count_nxt;
         tag_r <= tag_nxt;
         div_r <= div_nxt;
      end
   end

   // Read answer flops; valid and fault are one-cycle pulses, data holds
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rdValid_r <= 1'b0;
         rdFault_r <= 1'b0;
         rdEdx_r <= 32'h0000_0000;
         rdEax_r <= 32'h0000_0000;
         rdEcx_r <= 32'h0000_0000;
      end else begin
         rdValid_r <= rdValid_nxt;
         rdFault_r <= rdFault_nxt;
         rdEdx_r <= rdEdx_nxt;
         rdEax_r <= rdEax_nxt;
         rdEcx_r <= rdEcx_nxt;
      end
   end

   // Feature-query answer flops
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         featValid_r <= 1'b0;
         featEdx_r <= 32'h0000_0000;
      end else begin
         featValid_r <= featValid_nxt;
         featEdx_r <= featEdx_nxt;
      end
   end

   // Outputs come straight from the answer flops
   assign rdValid = rdValid_r;
   assign rdFault = rdFault_r;
   assign rdEdx = rdEdx_r;
   assign rdEax = rdEax_r;
   assign rdEcx = rdEcx_r;
   assign featureValid = featValid_r;
   assign featureEdx = featEdx_r;

   // Core counting and read checks
   a_reset_clears: assert property (@(posedge core_clk) !resetn |=> count_r == 64'h0) // RULE1
      else $error("counter not cleared by reset");
   a_legacy_inc: assert property (@(posedge core_clk) disable iff (!resetn) // RULE4
      (!constRateMode && deepSleepPinN && !cntWr) |=> count_r == $past(count_r) + 64'h1)
      else $error("legacy mode did not add one");
   a_halt_counts: assert property (@(posedge core_clk) disable iff (!resetn) // RULE2
      (!constRateMode && deepSleepPinN && !cntWr && (haltState || !stopClockPinN))
      |=> count_r != $past(count_r))
      else $error("counter stalled while halted");
   a_sleep_stop: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
      (!deepSleepPinN && !cntWr) |=> count_r == $past(count_r))
      else $error("counter moved in deep sleep");
   a_user_block: assert property (@(posedge core_clk) disable iff (!resetn) // RULE9
      (anyRead && userReadDisableFlag && privLevel != 2'h0) |=> rdFault && !rdValid)
      else $error("blocked read not refused");
   a_read_value: assert property (@(posedge core_clk) disable iff (!resetn) // RULE12
      (anyRead && !userBlocked) |=> {rdEdx, rdEax} == $past(count_r))
      else $error("read value mismatch");
   a_tag_read: assert property (@(posedge core_clk) disable iff (!resetn) // RULE19
      (counterAndTagReadInstr && !userBlocked) |=> rdEcx == $past(tag_r))
      else $error("tag read mismatch");
   a_write_load: assert property (@(posedge core_clk) disable iff (!resetn) // RULE14
      (cntWr && FULL_WIDTH_WRITE) |=> count_r == $past(modelRegWrData))
      else $error("counter write not loaded");
   a_feature_bit: assert property (@(posedge core_clk) disable iff (!resetn) // RULE15
      (featureQueryInstr && featureLeaf == tsc_pkg::LEAF_BASIC) |=> featureEdx[tsc_pkg::COUNTER_PRESENT_BIT])
      else $error("counter feature bit missing");

   // Reset and storage
   a_tag_reset: assert property (@(posedge core_clk) // RULE18
      !resetn |=> tag_r == tsc_pkg::TAG_RESET)
      else $error("tag not cleared by reset");
   a_div_reset: assert property (@(posedge core_clk) // RULE5
      !resetn |=> div_r == tsc_pkg::CONST_DIV_DEFAULT)
      else $error("divider not preset by reset");
   a_out_reset: assert property (@(posedge core_clk) // RULE1
      !resetn |=> !rdValid && !rdFault && !featureValid)
      else $error("answer pulse during reset");
   a_tag_write: assert property (@(posedge core_clk) disable iff (!resetn) // RULE18
      tagWr |=> tag_r == $past(modelRegWrData[31:0]))
      else $error("tag write not loaded");
   a_legacy_write: assert property (@(posedge core_clk) disable iff (!resetn) // RULE13
      (cntWr && !FULL_WIDTH_WRITE)
      |=> count_r[63:32] == 32'h0000_0000 && count_r[31:0] == $past(modelRegWrData[31:0]))
      else $error("legacy write did not clear upper half");
   a_wrap: assert property (@(posedge core_clk) disable iff (!resetn) // RULE22
      (count_r == 64'hFFFF_FFFF_FFFF_FFFF && tick && !cntWr)
      |=> count_r == tsc_pkg::COUNT_RESET)
      else $error("counter did not wrap to zero");

   // Constant-rate pacing; a missing reference pulse must freeze the count
   a_const_hold: assert property (@(posedge core_clk) disable iff (!resetn) // RULE5
      (INVARIANT_SUPPORT && constRateMode && !refTick && !cntWr) |=> count_r == $past(count_r))
      else $error("constant-rate count moved without a reference pulse");
   a_const_step: assert property (@(posedge core_clk) disable iff (!resetn) // RULE6
      (INVARIANT_SUPPORT && constRateMode && refTick && div_r == 8'h00
      && deepSleepPinN && !cntWr)
      |=> count_r == $past(count_r) + tsc_pkg::COUNT_ONE)
      else $error("constant-rate tick was not exactly one");
   a_div_reload: assert property (@(posedge core_clk) disable iff (!resetn) // RULE5
      (constRateMode && refTick && div_r == 8'h00) |=> div_r == $past(constRateDiv))
      else $error("divider not reloaded after tick");

   // Read answers; a refused read must not leak the count into the data flops
   a_fault_no_data: assert property (@(posedge core_clk) disable iff (!resetn) // RULE9
      (anyRead && userBlocked) |=> $stable({rdEdx, rdEax, rdEcx}))
      else $error("refused read changed the answer data");
   a_model_cnt_read: assert property (@(posedge core_clk) disable iff (!resetn) // RULE11
      (modelRegReadInstr && !anyRead && modelRegAddr == tsc_pkg::CYCLE_COUNT_ADDR)
      |=> rdValid && {rdEdx, rdEax} == $past(count_r))
      else $error("model read of counter mismatch");
   a_model_tag_read: assert property (@(posedge core_clk) disable iff (!resetn) // RULE18
      (modelRegReadInstr && !anyRead && modelRegAddr == tsc_pkg::COUNTER_TAG_ADDR)
      |=> rdValid && rdEdx == 32'h0000_0000 && rdEax == $past(tag_r))
      else $error("model read of tag mismatch");
   a_bad_addr: assert property (@(posedge core_clk) disable iff (!resetn) // RULE11
      (modelRegReadInstr && !anyRead && modelRegAddr != tsc_pkg::CYCLE_COUNT_ADDR
      && modelRegAddr != tsc_pkg::COUNTER_TAG_ADDR) |=> rdFault && !rdValid)
      else $error("unknown model register not refused");
   a_ecx_hold: assert property (@(posedge core_clk) disable iff (!resetn) // RULE19
      (counterReadInstr && !counterAndTagReadInstr) |=> $stable(rdEcx))
      else $error("plain read disturbed the tag answer");
   a_idle_quiet: assert property (@(posedge core_clk) disable iff (!resetn) // RULE10
      !(anyRead || modelRegReadInstr) |=> !rdValid && !rdFault)
      else $error("answer pulse without a request");

   // Feature answers
   a_feature_ext1: assert property (@(posedge core_clk) disable iff (!resetn) // RULE21
      (featureQueryInstr && featureLeaf == tsc_pkg::LEAF_EXT1)
      |=> featureValid && featureEdx[tsc_pkg::TAG_READ_PRESENT_BIT])
      else $error("combined-read feature bit missing");
   a_feature_ext7: assert property (@(posedge core_clk) disable iff (!resetn) // RULE16
      (featureQueryInstr && featureLeaf == tsc_pkg::LEAF_EXT7)
      |=> featureEdx[tsc_pkg::INVARIANT_BIT] == INVARIANT_SUPPORT)
      else $error("invariant feature bit wrong");
   a_feature_idle: assert property (@(posedge core_clk) disable iff (!resetn) // RULE15
      !featureQueryInstr |=> !featureValid && $stable(featureEdx))
      else $error("feature answer changed without a query");

   // Main scenarios worth seeing at least once
   c_plain_read: cover property (@(posedge core_clk) anyRead && !userBlocked);
   c_tag_read: cover property (@(posedge core_clk) counterAndTagReadInstr && !userBlocked);
   c_blocked_read: cover property (@(posedge core_clk) anyRead && userBlocked);
   c_count_write: cover property (@(posedge core_clk) cntWr);
   c_const_tick: cover property (@(posedge core_clk) constRateMode && tick);
endmodule : tsc_timestamp_counter

// file: tb.sv
`timescale 1ns/1ps
module tb;
   `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
      $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
   logic core_clk = 1'b0, resetn = 1'b0, constRateMode = 1'b0, refTick = 1'b0;
   logic haltState = 1'b0, stopClockPinN = 1'b1, deepSleepPinN = 1'b1;
   logic userReadDisableFlag = 1'b0, featureQueryInstr = 1'b0;
   logic counterReadInstr = 1'b0, counterAndTagReadInstr = 1'b0;
   logic modelRegReadInstr = 1'b0, modelRegWriteInstr = 1'b0;
   logic [1:0] privLevel = 2'h0;
   logic [7:0] constRateDiv = 8'h00;
   logic [31:0] modelRegAddr = 32'h0, featureLeaf = 32'h0, seed = 32'h0001_7DEC;
   logic [63:0] modelRegWrData = 64'h0, mCnt, snap, last, lCnt, lSnap;
   logic [31:0] mTag, tSnap, rdEdx, rdEax, rdEcx, featureEdx, lEdx, lEax, lEcx, lFeatEdx;
   logic rdValid, rdFault, featureValid, lValid, lFault, lFeatValid;
   logic [7:0] mDiv;
   int mismatches = 0, n_tests = 0;
   localparam logic [31:0] CNT = tsc_pkg::CYCLE_COUNT_ADDR, TAG = tsc_pkg::COUNTER_TAG_ADDR;
   tsc_timestamp_counter uut (.core_clk(core_clk), .resetn(resetn),
      .constRateMode(constRateMode), .constRateDiv(constRateDiv), .refTick(refTick),
      .haltState(haltState), .stopClockPinN(stopClockPinN), .deepSleepPinN(deepSleepPinN),
      .userReadDisableFlag(userReadDisableFlag), .privLevel(privLevel),
      .counterReadInstr(counterReadInstr), .counterAndTagReadInstr(counterAndTagReadInstr),
      .modelRegReadInstr(modelRegReadInstr), .modelRegWriteInstr(modelRegWriteInstr),
      .modelRegAddr(modelRegAddr), .modelRegWrData(modelRegWrData),
      .featureQueryInstr(featureQueryInstr), .featureLeaf(featureLeaf), .rdValid(rdValid),
      .rdFault(rdFault), .rdEdx(rdEdx), .rdEax(rdEax), .rdEcx(rdEcx),
      .featureValid(featureValid), .featureEdx(featureEdx));
   // Older-style part: low-half writes, no constant-rate pacing
   tsc_timestamp_counter #(.INVARIANT_SUPPORT(1'b0), .FULL_WIDTH_WRITE(1'b0)) uutLegacy (
      .core_clk(core_clk), .resetn(resetn),
      .constRateMode(constRateMode), .constRateDiv(constRateDiv), .refTick(refTick),
      .haltState(haltState), .stopClockPinN(stopClockPinN), .deepSleepPinN(deepSleepPinN),
      .userReadDisableFlag(userReadDisableFlag), .privLevel(privLevel),
      .counterReadInstr(counterReadInstr), .counterAndTagReadInstr(counterAndTagReadInstr),
      .modelRegReadInstr(modelRegReadInstr), .modelRegWriteInstr(modelRegWriteInstr),
      .modelRegAddr(modelRegAddr), .modelRegWrData(modelRegWrData),
      .featureQueryInstr(featureQueryInstr), .featureLeaf(featureLeaf), .rdValid(lValid),
      .rdFault(lFault), .rdEdx(lEdx), .rdEax(lEax), .rdEcx(lEcx),
      .featureValid(lFeatValid), .featureEdx(lFeatEdx));
   // Clock
   always #5 core_clk = ~core_clk;
   // Reference model; snapshots hold what a request taken at this edge must see
   always @(posedge core_clk) begin
      snap = mCnt;
      lSnap = lCnt;
      tSnap = mTag;
      if (!resetn) begin
         mCnt = 64'h0;
         lCnt = 64'h0;
         mTag = 32'h0;
         mDiv = tsc_pkg::CONST_DIV_DEFAULT;
      end else begin
         if (modelRegWriteInstr && modelRegAddr == TAG) mTag = modelRegWrData[31:0];
         if (modelRegWriteInstr && modelRegAddr == CNT) begin
            mCnt = modelRegWrData;
            lCnt = {32'h0, modelRegWrData[31:0]};
         end else begin
            if (deepSleepPinN && (!constRateMode || (refTick && mDiv == 8'h00)))
               mCnt = mCnt + 64'h1;
            if (deepSleepPinN) lCnt = lCnt + 64'h1;
         end
         if (constRateMode && refTick) mDiv = (mDiv == 8'h00) ? constRateDiv : mDiv - 8'h01;
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // One request; k = {write, model read, tag read, counter read}
   task automatic rq(input logic [3:0] k, input logic [31:0] a, input logic [63:0] d);
      logic ef;
      @(negedge core_clk);
      {modelRegWriteInstr, modelRegReadInstr, counterAndTagReadInstr, counterReadInstr} = k;
      modelRegAddr = a;
      modelRegWrData = d;
      @(negedge core_clk);
      {modelRegWriteInstr, modelRegReadInstr, counterAndTagReadInstr, counterReadInstr} = 4'h0;
      if (k[3]) return;
      ef = k[2] ? (a != CNT && a != TAG) : (userReadDisableFlag && privLevel != 2'h0);
      `CHK(rdFault, ef)
      `CHK(rdValid, !ef)
      if (!ef && k[2]) `CHK({rdEdx, rdEax}, (a == CNT) ? snap : {32'h0, tSnap})
      if (!ef && !k[2]) `CHK({rdEdx, rdEax}, snap)
      if (!ef && k[1]) `CHK(rdEcx, tSnap)
      `CHK(lFault, ef)
      `CHK(lValid, !ef)
      if (!ef && (!k[2] || a == CNT)) `CHK({lEdx, lEax}, lSnap)
      if (!ef && k[1]) `CHK(lEcx, tSnap)
   endtask : rq
   task automatic fq(input logic [31:0] leaf, input int b);
      @(negedge core_clk);
      featureQueryInstr = 1'b1;
      featureLeaf = leaf;
      @(negedge core_clk);
      featureQueryInstr = 1'b0;
      `CHK(featureValid, 1'b1)
      `CHK(featureEdx[b], 1'b1)
      `CHK(lFeatValid, 1'b1)
      `CHK(lFeatEdx[b], leaf != tsc_pkg::LEAF_EXT7)
   endtask : fq
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // Hang guard: every wait in the bench is bounded by this
   initial begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      end_sim;
   end
   // Main sequence
   initial begin
      repeat (4) @(negedge core_clk);
      resetn = 1'b1;
      rq(4'h1, 32'h0, 64'h0);
      last = {rdEdx, rdEax};
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         {haltState, stopClockPinN} = seed[1:0];
         rq(4'h1, 32'h0, 64'h0);
         `CHK({rdEdx, rdEax} > last, 1'b1)
         last = {rdEdx, rdEax};
      end
      $display("test count done");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         rq(4'h8, CNT, {seed, ~seed});
         rq(4'h4, CNT, 64'h0);
         rq(4'h8, TAG, {32'h0, seed});
         rq(4'h2, 32'h0, 64'h0);
         rq(4'h4, TAG, 64'h0);
      end
      rq(4'h8, CNT, 64'hFFFF_FFFF_FFFF_FFFF);
      rq(4'h1, 32'h0, 64'h0);
      rq(4'h4, 32'h0000_0011, 64'h0);
      $display("test write done");
      userReadDisableFlag = 1'b1;
      for (int p = 0; p < 4; p++) begin
         privLevel = p[1:0];
         rq(4'h1, 32'h0, 64'h0);
         rq(4'h2, 32'h0, 64'h0);
      end
      {userReadDisableFlag, privLevel, deepSleepPinN} = 4'h0;
      rq(4'h1, 32'h0, 64'h0);
      last = {rdEdx, rdEax};
      rq(4'h1, 32'h0, 64'h0);
      `CHK({rdEdx, rdEax}, last)
      deepSleepPinN = 1'b1;
      $display("test gate done");
      fq(tsc_pkg::LEAF_BASIC, tsc_pkg::COUNTER_PRESENT_BIT);
      fq(tsc_pkg::LEAF_EXT1, tsc_pkg::TAG_READ_PRESENT_BIT);
      fq(tsc_pkg::LEAF_EXT7, tsc_pkg::INVARIANT_BIT);
      constRateMode = 1'b1;
      for (int i = 0; i < 20; i++) begin
         seed = lfsr(seed);
         {constRateDiv[1:0], haltState, refTick} = seed[3:0];
         @(negedge core_clk);
      end
      refTick = 1'b0;
      repeat (3) @(negedge core_clk);
      rq(4'h1, 32'h0, 64'h0);
      $display("test rate done");
      end_sim;
   end
endmodule : tb
